// >>> verilog/wdc_pkg.sv
// Purpose: Shared constants, types and helpers for the watchdog control block
// Assumes: 32-bit classic Wishbone register bus, word aligned accesses
// Notes:   Byte addresses; the low two address bits are ignored
package wdc_pkg;

   localparam int DAT_W = 32;
   localparam int SEL_W = 4;
   localparam int ADR_W = 8;
   localparam int PS_W  = 5;
   localparam int EV_W  = 3;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [ADR_W-1:0] ADR_CTL       = 8'h00;
   localparam logic [ADR_W-1:0] ADR_CLR       = 8'h04;
   localparam logic [ADR_W-1:0] ADR_SET       = 8'h08;
   localparam logic [ADR_W-1:0] ADR_INV       = 8'h0C;
   localparam logic [ADR_W-1:0] ADR_STAT      = 8'h10;
   localparam logic [ADR_W-1:0] ADR_MASK      = 8'h14;
   localparam logic [ADR_W-1:0] ADR_WORD_MASK = 8'hFC;
   localparam logic [ADR_W-1:0] ADR_CTL_BLK   = 8'hF0;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int ON_BIT  = 15;
   localparam int PS_LSB  = 2;
   localparam int WIN_BIT = 1;
   localparam int CLR_BIT = 0;
   localparam logic [DAT_W-1:0] CTL_IMPL_MASK = 32'h0000807F;

   // Status and mask fields
   localparam int EV_TIMEOUT  = 0;
   localparam int EV_WAKE     = 1;
   localparam int EV_WINFAULT = 2;

   // Window opens for the last quarter of the period
   localparam int WIN_SHIFT = 2;

   typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} wdc_op_t;

   function automatic logic [ADR_W-1:0] word_of(input logic [ADR_W-1:0] adr);
      word_of = adr & ADR_WORD_MASK;
   endfunction

   function automatic wdc_op_t alias_op(input logic [ADR_W-1:0] adr);
      case (word_of(adr))
         ADR_CLR: alias_op = OP_CLR;
         ADR_SET: alias_op = OP_SET;
         ADR_INV: alias_op = OP_INV;
         default: alias_op = OP_WRITE;
      endcase
   endfunction

   // Applies a plain or atomic write, only in the selected byte lanes
   function automatic logic [DAT_W-1:0] alias_apply(input wdc_op_t          op,
                                                    input logic [DAT_W-1:0] base,
                                                    input logic [DAT_W-1:0] data,
                                                    input logic [SEL_W-1:0] sel);
      logic [DAT_W-1:0] m;
      logic [DAT_W-1:0] r;
      m = '0;
      for (int i = 0; i < SEL_W; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      unique case (op)
         OP_WRITE: r = data;
         OP_CLR:   r = base & ~data;
         OP_SET:   r = base | data;
         OP_INV:   r = base ^ data;
      endcase
      alias_apply = (base & ~m) | (r & m);
   endfunction

endpackage

// >>> verilog/wdc_if.sv
// Purpose: Access channel between the bus slave and the register logic
// Assumes: One access per strobe, answered in the same cycle
// Notes:   Read data is combinational from the register side
`timescale 1ns/1ps
interface wdc_if;
   logic                          stb;
   logic                          we;
   logic [wdc_pkg::ADR_W-1:0]     adr;
   logic [wdc_pkg::SEL_W-1:0]     sel;
   logic [wdc_pkg::DAT_W-1:0]     wdat;
   logic [wdc_pkg::DAT_W-1:0]     rdat;

   modport bus  (output stb, we, adr, sel, wdat, input rdat);
   modport regs (input stb, we, adr, sel, wdat, output rdat);
endinterface

// >>> verilog/wdc_wb_slave.sv
// Purpose: Classic Wishbone slave front end with one-wait-state ack
// Assumes: Master holds the request until it sees ack
// Notes:   Access strobe fires once, in the cycle before ack rises
`timescale 1ns/1ps
module wdc_wb_slave (
   input  wire logic                       clk_i,     // Clock
   input  wire logic                       rst_i,     // Sync reset
   input  wire logic                       wb_cyc_i,  // Bus cycle
   input  wire logic                       wb_stb_i,  // Strobe
   input  wire logic                       wb_we_i,   // Write enable
   input  wire logic [wdc_pkg::ADR_W-1:0]  wb_adr_i,  // Byte address
   input  wire logic [wdc_pkg::SEL_W-1:0]  wb_sel_i,  // Byte lanes
   input  wire logic [wdc_pkg::DAT_W-1:0]  wb_dat_i,  // Write data
   output logic      [wdc_pkg::DAT_W-1:0]  wb_dat_o,  // Read data
   output logic                            wb_ack_o,  // Acknowledge
   wdc_if.bus                              acc        // Register access
);
   typedef struct packed {
      logic                      ack;
      logic [wdc_pkg::DAT_W-1:0] rdat;
   } wdc_slv_state_t;

   wdc_slv_state_t st_r;
   wdc_slv_state_t st_nxt;

   assign acc.stb  = wb_cyc_i & wb_stb_i & ~st_r.ack;
   assign acc.we   = wb_we_i;
   assign acc.adr  = wb_adr_i;
   assign acc.sel  = wb_sel_i;
   assign acc.wdat = wb_dat_i;

   always_comb begin
      st_nxt     = st_r;
      st_nxt.ack = acc.stb;
      if (acc.stb & ~wb_we_i) begin
         st_nxt.rdat = acc.rdat;
      end
      if (rst_i) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   assign wb_ack_o = st_r.ack;
   assign wb_dat_o = st_r.rdat;

   property p_ack_single;
      @(posedge clk_i) disable iff (rst_i) st_r.ack |=> !st_r.ack;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");
endmodule

// >>> verilog/wdc_counter.sv
// Purpose: Watchdog count driven by low-power oscillator ticks
// Assumes: Tick is a one-cycle pulse synchronous to clk_i
// Notes:   Clear has priority over counting
`timescale 1ns/1ps
module wdc_counter #(
   parameter int CNT_W = 32                   // Count width
) (
   input  wire logic              clk_i,      // Clock
   input  wire logic              rst_i,      // Sync reset
   input  wire logic              tick_i,     // Oscillator tick
   input  wire logic              run_i,      // Watchdog running
   input  wire logic              clear_i,    // Restart count
   output logic      [CNT_W-1:0]  count_o     // Current count
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
   } wdc_cnt_state_t;

   wdc_cnt_state_t st_r;
   wdc_cnt_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (rst_i | clear_i) begin
         st_nxt.count = '0;
      end else if (run_i & tick_i) begin
         st_nxt.count = st_r.count + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   assign count_o = st_r.count;
endmodule

// >>> verilog/wdc_watchdog_control.sv
// Purpose: Watchdog control register, time-out, window check and events
// Assumes: Oscillator tick and configuration inputs synchronous to clk_i
// Notes:   Configuration enable and postscale are caught while reset is high
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////////////////////
module wdc_watchdog_control #(
   parameter int CNT_W = 32                                // Watchdog count width
) (
   input  wire logic                          clk_i,           // Clock, 100 MHz
   input  wire logic                          rst_i,           // Sync reset, active high
   input  wire logic                          wb_cyc_i,        // Wishbone cycle
   input  wire logic                          wb_stb_i,        // Wishbone strobe
   input  wire logic                          wb_we_i,         // Wishbone write enable
   input  wire logic [wdc_pkg::ADR_W-1:0]     wb_adr_i,        // Wishbone byte address
   input  wire logic [wdc_pkg::SEL_W-1:0]     wb_sel_i,        // Wishbone byte lanes
   input  wire logic [wdc_pkg::DAT_W-1:0]     wb_dat_i,        // Wishbone write data
   output logic      [wdc_pkg::DAT_W-1:0]     wb_dat_o,        // Wishbone read data
   output logic                               wb_ack_o,        // Wishbone acknowledge
   input  wire logic                          cfg_enable_i,    // Configuration enable
   input  wire logic [wdc_pkg::PS_W-1:0]      cfg_postscale_i, // Configured postscale
   input  wire logic                          lp_tick_i,       // Low-power clock tick
   input  wire logic                          low_power_i,     // Sleep or idle
   output logic                               running_o,       // Watchdog running
   output logic                               device_reset_o,  // Device reset pulse
   output logic                               wake_o,          // Wake pulse
   output logic                               irq_o            // Interrupt, level
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic                        cfg_en;
      logic                        sw_on;
      logic                        win_en;
      logic [wdc_pkg::PS_W-1:0]    shadow_ps;
      logic [wdc_pkg::EV_W-1:0]    ev_stat;
      logic [wdc_pkg::EV_W-1:0]    ev_mask;
      logic                        dev_rst;
      logic                        wake;
   } wdc_ctl_state_t;

   wdc_ctl_state_t            st_r;
   wdc_ctl_state_t            st_nxt;
   wdc_if                     acc_if ();
   wdc_pkg::wdc_op_t          op;
   logic                      running;
   logic                      ctl_wr;
   logic                      stat_rd;
   logic                      mask_wr;
   logic                      restart;
   logic                      expire;
   logic                      win_open;
   logic                      win_fault;
   logic [wdc_pkg::EV_W-1:0]  ev;
   logic [wdc_pkg::DAT_W-1:0] ctl_view;
   logic [wdc_pkg::DAT_W-1:0] ctl_new;
   logic [wdc_pkg::DAT_W-1:0] mask_new;
   logic [wdc_pkg::DAT_W-1:0] rd_data;
   logic [CNT_W-1:0]          count;
   logic [CNT_W-1:0]          terminal;

   // Last count of a period of 2**postscale ticks
   function automatic logic [CNT_W-1:0] term_of(input logic [wdc_pkg::PS_W-1:0] ps);
      term_of = (CNT_W'(1) << ps) - CNT_W'(1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus front end and count
   wdc_wb_slave i_wdc_wb_slave (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .acc      (acc_if.bus)
   );

   wdc_counter #(
      .CNT_W (CNT_W)
   ) i_wdc_counter (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tick_i  (lp_tick_i),
      .run_i   (running),
      .clear_i (restart | expire | ~running),
      .count_o (count)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Control register view and decode
   // enable reads running
   assign running = st_r.cfg_en | st_r.sw_on;

   always_comb begin
      ctl_view                                        = '0;
      ctl_view[wdc_pkg::ON_BIT]                       = running;
      ctl_view[wdc_pkg::PS_LSB +: wdc_pkg::PS_W]      = st_r.shadow_ps;
      ctl_view[wdc_pkg::WIN_BIT]                      = st_r.win_en;
   end

   assign op       = wdc_pkg::alias_op(acc_if.adr);
   assign ctl_wr   = acc_if.stb & acc_if.we
                     & ((acc_if.adr & wdc_pkg::ADR_CTL_BLK) == wdc_pkg::ADR_CTL);
   assign stat_rd  = acc_if.stb & ~acc_if.we
                     & (wdc_pkg::word_of(acc_if.adr) == wdc_pkg::ADR_STAT);
   assign mask_wr  = acc_if.stb & acc_if.we
                     & (wdc_pkg::word_of(acc_if.adr) == wdc_pkg::ADR_MASK);
   assign ctl_new  = wdc_pkg::alias_apply(op, ctl_view, acc_if.wdat, acc_if.sel);
   assign mask_new = wdc_pkg::alias_apply(wdc_pkg::OP_WRITE,
                                          {{(wdc_pkg::DAT_W-wdc_pkg::EV_W){1'h0}}, st_r.ev_mask},
                                          acc_if.wdat, acc_if.sel);

   always_comb begin
      case (wdc_pkg::word_of(acc_if.adr))
         wdc_pkg::ADR_CTL,
         wdc_pkg::ADR_CLR,
         wdc_pkg::ADR_SET,
         wdc_pkg::ADR_INV:  rd_data = ctl_view;
         wdc_pkg::ADR_STAT: rd_data = {{(wdc_pkg::DAT_W-wdc_pkg::EV_W){1'h0}}, st_r.ev_stat};
         wdc_pkg::ADR_MASK: rd_data = {{(wdc_pkg::DAT_W-wdc_pkg::EV_W){1'h0}}, st_r.ev_mask};
         default:           rd_data = '0;
      endcase
   end
   assign acc_if.rdat = rd_data;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Time-out, restart and window
   // postscale sets period
   assign terminal = term_of(st_r.shadow_ps);
   assign win_open = count >= (terminal - (terminal >> wdc_pkg::WIN_SHIFT));

   assign restart   = ctl_wr & ctl_new[wdc_pkg::CLR_BIT] & running;
   assign win_fault = restart & st_r.win_en & ~win_open;
   assign expire    = running & lp_tick_i & (count == terminal) & ~restart;

   always_comb begin
      ev                       = '0;
      ev[wdc_pkg::EV_TIMEOUT]  = expire & ~low_power_i;
      ev[wdc_pkg::EV_WAKE]     = expire & low_power_i;
      ev[wdc_pkg::EV_WINFAULT] = win_fault;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt = st_r;
      if (ctl_wr) begin
         st_nxt.sw_on  = ctl_new[wdc_pkg::ON_BIT];
         st_nxt.win_en = ctl_new[wdc_pkg::WIN_BIT];
      end
      if (mask_wr) begin
         st_nxt.ev_mask = mask_new[wdc_pkg::EV_W-1:0];
      end
      // Set wins over read clear
      st_nxt.ev_stat = (st_r.ev_stat & ~{wdc_pkg::EV_W{stat_rd}}) | ev;
      st_nxt.dev_rst = ev[wdc_pkg::EV_TIMEOUT] | win_fault;
      st_nxt.wake    = ev[wdc_pkg::EV_WAKE];
      if (rst_i) begin
         st_nxt           = '0;
         st_nxt.shadow_ps = cfg_postscale_i;
         st_nxt.cfg_en    = cfg_enable_i;
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   assign running_o      = running;
   assign device_reset_o = st_r.dev_rst;
   assign wake_o         = st_r.wake;
   assign irq_o          = |(st_r.ev_stat & st_r.ev_mask);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_on_start;
      @(posedge clk_i) disable iff (rst_i)
         (ctl_wr && op == wdc_pkg::OP_WRITE && acc_if.sel[1] && acc_if.wdat[wdc_pkg::ON_BIT])
         |=> running_o;
   endproperty
   a_on_start: assert property (p_on_start) else $error("enable write did not start");

   property p_cfg_keeps;
      @(posedge clk_i) disable iff (rst_i) st_r.cfg_en |-> running_o;
   endproperty
   a_cfg_keeps: assert property (p_cfg_keeps) else $error("configured watchdog stopped");

   property p_sw_stop;
      @(posedge clk_i) disable iff (rst_i)
         (!st_r.cfg_en && ctl_wr && op == wdc_pkg::OP_CLR && acc_if.sel[1]
          && acc_if.wdat[wdc_pkg::ON_BIT]) |=> !running_o;
   endproperty
   a_sw_stop: assert property (p_sw_stop) else $error("software watchdog not stopped");

   property p_on_read;
      @(posedge clk_i) disable iff (rst_i)
         (acc_if.stb && !acc_if.we && wdc_pkg::word_of(acc_if.adr) == wdc_pkg::ADR_CTL)
         |=> wb_dat_o[wdc_pkg::ON_BIT] == $past(running_o) && wb_ack_o;
   endproperty
   a_on_read: assert property (p_on_read) else $error("enable bit misread");

   property p_ps_reset;
      @(posedge clk_i) disable iff (rst_i)
         $past(rst_i) |-> st_r.shadow_ps == $past(cfg_postscale_i);
   endproperty
   a_ps_reset: assert property (p_ps_reset) else $error("shadow not loaded at reset");

   property p_ps_ro;
      @(posedge clk_i) disable iff (rst_i) !$past(rst_i) |-> $stable(st_r.shadow_ps);
   endproperty
   a_ps_ro: assert property (p_ps_ro) else $error("shadow changed after reset");

   property p_win_sel;
      @(posedge clk_i) disable iff (rst_i)
         (ctl_wr && op == wdc_pkg::OP_SET && acc_if.sel[0] && acc_if.wdat[wdc_pkg::WIN_BIT])
         |=> st_r.win_en ##1 (st_r.win_en || $past(ctl_wr));
   endproperty
   a_win_sel: assert property (p_win_sel) else $error("window set alias failed");

   property p_restart;
      @(posedge clk_i) disable iff (rst_i) restart |=> count == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not clear count");

   property p_zero_noop;
      @(posedge clk_i) disable iff (rst_i)
         (ctl_wr && op == wdc_pkg::OP_WRITE && acc_if.sel[0] && !acc_if.wdat[wdc_pkg::CLR_BIT]
          && running && !lp_tick_i) |=> $stable(count);
   endproperty
   a_zero_noop: assert property (p_zero_noop) else $error("zero restart changed count");

   property p_inv_alias;
      @(posedge clk_i) disable iff (rst_i)
         (ctl_wr && op == wdc_pkg::OP_INV && acc_if.sel[0] && acc_if.wdat[wdc_pkg::WIN_BIT])
         |=> st_r.win_en != $past(st_r.win_en);
   endproperty
   a_inv_alias: assert property (p_inv_alias) else $error("invert alias failed");

   property p_unimpl;
      @(posedge clk_i) disable iff (rst_i) (ctl_view & ~wdc_pkg::CTL_IMPL_MASK) == '0;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

   property p_tick_only;
      @(posedge clk_i) disable iff (rst_i)
         (!lp_tick_i && running && !restart) |=> $stable(count);
   endproperty
   a_tick_only: assert property (p_tick_only) else $error("count moved without tick");

   property p_timeout;
      @(posedge clk_i) disable iff (rst_i)
         (running && lp_tick_i && count == terminal && !restart && !low_power_i)
         |=> device_reset_o && !wake_o ##1 !device_reset_o || $past(win_fault || expire);
   endproperty
   a_timeout: assert property (p_timeout) else $error("time-out gave no reset");

   property p_wake;
      @(posedge clk_i) disable iff (rst_i)
         (expire && low_power_i) |=> wake_o && !device_reset_o && st_r.ev_stat[wdc_pkg::EV_WAKE];
   endproperty
   a_wake: assert property (p_wake) else $error("low power expiry did not wake");

   property p_win_fault;
      @(posedge clk_i) disable iff (rst_i)
         (restart && st_r.win_en && !win_open) |=> device_reset_o
         && st_r.ev_stat[wdc_pkg::EV_WINFAULT];
   endproperty
   a_win_fault: assert property (p_win_fault) else $error("early restart not faulted");

   property p_irq;
      @(posedge clk_i) disable iff (rst_i)
         $rose(irq_o) |-> $past(|ev) || $past(mask_wr);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt rose without cause");

   property p_stat_clear;
      @(posedge clk_i) disable iff (rst_i) (stat_rd && !(|ev)) |=> st_r.ev_stat == '0;
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status read did not clear");

   property p_irq_masked;
      @(posedge clk_i) disable iff (rst_i)
         (!irq_o && !mask_wr && (ev & st_r.ev_mask) == '0) |=> !irq_o;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked event raised interrupt");

   property p_wb_answer;
      @(posedge clk_i) disable iff (rst_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
   endproperty
   a_wb_answer: assert property (p_wb_answer) else $error("bus request not answered");

   c_timeout: cover property (@(posedge clk_i) disable iff (rst_i) $rose(device_reset_o));
   c_wake:    cover property (@(posedge clk_i) disable iff (rst_i) wake_o);
   c_fault:   cover property (@(posedge clk_i) disable iff (rst_i) win_fault);
   c_irq_clr: cover property (@(posedge clk_i) disable iff (rst_i) irq_o ##1 stat_rd);
   c_win_ok:  cover property (@(posedge clk_i) disable iff (rst_i)
                             restart && st_r.win_en && win_open);
endmodule

// >>> test/wdc_watchdog_control_tb.sv
// Purpose: Self-checking bench for the watchdog control block
// Assumes: Classic Wishbone master, one-cycle oscillator ticks
// Notes:   Reset and wake pulses are counted by a monitor
`timescale 1ns/1ps
module wdc_watchdog_control_tb;
   logic                         clk_i           = 1'b0;
   logic                         rst_i           = 1'b1;
   logic                         wb_cyc_i        = 1'b0;
   logic                         wb_stb_i        = 1'b0;
   logic                         wb_we_i         = 1'b0;
   logic [wdc_pkg::ADR_W-1:0]    wb_adr_i        = 8'h00;
   logic [wdc_pkg::SEL_W-1:0]    wb_sel_i        = 4'hF;
   logic [wdc_pkg::DAT_W-1:0]    wb_dat_i        = 32'h0;
   logic [wdc_pkg::DAT_W-1:0]    wb_dat_o;
   logic                         wb_ack_o;
   logic                         cfg_enable_i    = 1'b0;
   logic [wdc_pkg::PS_W-1:0]     cfg_postscale_i = 5'h00;
   logic                         lp_tick_i       = 1'b0;
   logic                         low_power_i     = 1'b0;
   logic                         running_o;
   logic                         device_reset_o;
   logic                         wake_o;
   logic                         irq_o;
   logic [31:0]                  q;
   int                           err_total       = 0;
   int                           checks          = 0;
   int                           n_rst           = 0;
   int                           n_wake          = 0;
   int                           s_rst;
   int                           s_wake;

   wdc_watchdog_control i_wdc_watchdog_control (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_enable_i(cfg_enable_i),
      .cfg_postscale_i(cfg_postscale_i), .lp_tick_i(lp_tick_i),
      .low_power_i(low_power_i), .running_o(running_o), .device_reset_o(device_reset_o),
      .wake_o(wake_o), .irq_o(irq_o));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // Pulse monitor
   always @(posedge clk_i) begin
      if (device_reset_o === 1'b1) n_rst++;
      if (wake_o === 1'b1) n_wake++;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         err_total++;
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      chk(nm, e, q);
   endtask

   task automatic do_reset(input logic en, input logic [4:0] ps);
      @(posedge clk_i);
      rst_i           <= 1'b1;
      cfg_enable_i    <= en;
      cfg_postscale_i <= ps;
      low_power_i     <= 1'b0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_i);
         lp_tick_i <= 1'b1;
         @(posedge clk_i);
         lp_tick_i <= 1'b0;
      end
   endtask

   task automatic mark;
      s_rst  = n_rst;
      s_wake = n_wake;
   endtask

   task automatic pulses(input int er, input int ew);
      repeat (4) @(posedge clk_i);
      chk("reset pulses", er, n_rst - s_rst);
      chk("wake pulses", ew, n_wake - s_wake);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      do_reset(1'b0, 5'h15);
      rdchk("ctl reset", wdc_pkg::ADR_CTL, 32'h00000054);
      chk("running", 32'h0, running_o);
      wr(wdc_pkg::ADR_CTL, 32'hFFFFFFFF);
      rdchk("ctl ones", wdc_pkg::ADR_CTL, 32'h00008056);
      chk("running", 32'h1, running_o);
      wr(wdc_pkg::ADR_CTL, 32'h0);
      rdchk("ctl off", wdc_pkg::ADR_CTL, 32'h00000054);
      rdchk("unmapped", 8'h40, 32'h0);
      wb(1'b1, wdc_pkg::ADR_SET, 32'h00008002, 4'hF);
      rdchk("set alias", wdc_pkg::ADR_CTL, 32'h00008056);
      wb(1'b1, wdc_pkg::ADR_CLR, 32'h00008002, 4'hF);
      rdchk("clr alias", wdc_pkg::ADR_CTL, 32'h00000054);
      wb(1'b1, wdc_pkg::ADR_INV, 32'h00008002, 4'hF);
      rdchk("inv alias", wdc_pkg::ADR_CTL, 32'h00008056);
      wb(1'b1, wdc_pkg::ADR_CLR, 32'h00008000, 4'h1);
      rdchk("lane off", wdc_pkg::ADR_CTL, 32'h00008056);
      $display("test regs done");
   endtask

   task automatic t_cfg;
      do_reset(1'b1, 5'h00);
      rdchk("cfg on", wdc_pkg::ADR_CTL, 32'h00008000);
      wr(wdc_pkg::ADR_CTL, 32'h0);
      rdchk("cfg stays", wdc_pkg::ADR_CTL, 32'h00008000);
      $display("test cfg done");
   endtask

   task automatic t_timeout;
      do_reset(1'b0, 5'h01);
      wr(wdc_pkg::ADR_MASK, 32'h7);
      rdchk("mask", wdc_pkg::ADR_MASK, 32'h7);
      wr(wdc_pkg::ADR_CTL, 32'h00008000);
      mark();
      tick(1);
      wr(wdc_pkg::ADR_CTL, 32'h00008001);
      tick(1);
      pulses(0, 0);
      wr(wdc_pkg::ADR_CTL, 32'h00008000);
      tick(1);
      pulses(1, 0);
      chk("irq set", 32'h1, irq_o);
      rdchk("status", wdc_pkg::ADR_STAT, 32'h1);
      chk("irq clear", 32'h0, irq_o);
      wr(wdc_pkg::ADR_MASK, 32'h0);
      low_power_i <= 1'b1;
      tick(2);
      pulses(1, 1);
      chk("irq masked", 32'h0, irq_o);
      rdchk("status wake", wdc_pkg::ADR_STAT, 32'h2);
      rdchk("status read", wdc_pkg::ADR_STAT, 32'h0);
      $display("test timeout done");
   endtask

   task automatic t_window;
      do_reset(1'b0, 5'h03);
      wr(wdc_pkg::ADR_MASK, 32'h7);
      wr(wdc_pkg::ADR_CTL, 32'h00008002);
      rdchk("ctl window", wdc_pkg::ADR_CTL, 32'h0000800E);
      mark();
      wr(wdc_pkg::ADR_CTL, 32'h00008003);
      pulses(1, 0);
      rdchk("status fault", wdc_pkg::ADR_STAT, 32'h4);
      tick(6);
      wr(wdc_pkg::ADR_CTL, 32'h00008003);
      pulses(1, 0);
      rdchk("status open", wdc_pkg::ADR_STAT, 32'h0);
      $display("test window done");
   endtask

   initial begin
      t_regs();
      t_cfg();
      t_timeout();
      t_window();
      report_and_stop();
   end
endmodule
